// [logic/fephy_pkg.sv]
// Constants, types and coding tables of the fast Ethernet PHY digital core.
// Function
// - Serialise MAC nibbles into a fast bit stream.
// - Encode 4B/5B, then scramble the coded stream.
// - Convert scrambled NRZ to NRZI, then MLT3.
// - Recover bit clock from NRZI edges, decode NRZ.
// - Descramble received stream, then 4B/5B decode.
// - Present decoded receive data as parallel nibbles.
// - Scrambler and descrambler only in 100 Mbit.
// - Split Manchester; keep receive clock running idle.
// - Pulse collision after each 10 Mbit frame not ended by lockout.
// - Transmit enable over 20 ms at 10 Mbit locks transmitter.
// - Enable low over 250 ms releases lockout.
// - All clocks derive from one reference.
// - Advertise abilities and compare with partner's.
// - Pick highest common mode by fixed priority.
// - Without advertisements, use parallel detection.
// - Negotiation enabled by strap or control bit.
// - Negotiation follows strap after reset; software may change.
// - Forced mode takes speed and duplex bits.
// - Interrupt output flags status changes.
// - MAC reads all registers, writes all but status.
// - Strap copied into control bit at release.
package fephy_pkg;
  localparam int CLK_NS = 50;
  localparam int NS_PER_MS = 1000000;
  localparam int JAB_MS = 20;
  localparam int UNJAB_MS = 250;
  localparam int JAB_CYC = JAB_MS * NS_PER_MS / CLK_NS;
  localparam int UNJAB_CYC = UNJAB_MS * NS_PER_MS / CLK_NS;
  localparam int SQE_NS = 1000;
  localparam int SQE_CYC = (SQE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RX_BIT_NS = 400;
  localparam int RX_BIT_CYC = RX_BIT_NS / CLK_NS;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_ADV = 8'h08;
  localparam logic [7:0] A_ISTAT = 8'h0c;
  localparam logic [7:0] A_IMASK = 8'h10;
  localparam int B_SPEED = 13;
  localparam int B_AN_EN = 12;
  localparam int B_DUPLEX = 8;
  localparam int ST_LINK = 0;
  localparam int ST_SPD = 1;
  localparam int ST_FDX = 2;
  localparam int ST_JAB = 3;
  localparam int ST_AN = 4;
  localparam int IS_LINK = 0;
  localparam int IS_JAB = 1;
  localparam int SY_LINE = 0;
  localparam int SY_STRAP = 1;
  localparam int SY_LPV = 2;
  localparam int SY_PD100 = 3;
  localparam int SY_PD10 = 4;
  localparam int SCR_T1 = 10;
  localparam int SCR_T2 = 8;
  localparam logic C_SPEED_RST = 1'b1;
  localparam logic C_DUP_RST = 1'b1;
  localparam logic C_AN_RST = 1'b1;
  localparam logic [3:0] ADV_RST = 4'hf;
  localparam logic [1:0] STP_CAP = 2'h2;
  localparam logic [1:0] STP_DONE = 2'h3;
  localparam logic [2:0] TB_LAST10 = 3'h3;
  localparam logic [2:0] TB_LAST100 = 3'h4;
  localparam logic [1:0] ML_POS = 2'h1;
  localparam logic [1:0] ML_NEG = 2'h3;
  localparam logic [1:0] ACT_HOLD = 2'h2;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0d;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [4:0] SYM_I = 5'h1f;
  // Mode codes are {link, speed 100, full duplex}.
  localparam logic [2:0] MD_100F = 3'h7;
  localparam logic [2:0] MD_100H = 3'h6;
  localparam logic [2:0] MD_10F = 3'h5;
  localparam logic [2:0] MD_10H = 3'h4;
  localparam logic [2:0] MD_NONE = 3'h0;
  localparam logic [15:0][4:0] ENC_TAB = {5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h17, 5'h16, 5'h13,
    5'h12, 5'h0f, 5'h0e, 5'h0b, 5'h0a, 5'h15, 5'h14, 5'h09, 5'h1e};
  typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fephy_tx_t;

  // Returns {valid, nibble} for a received five-bit code group.
  function automatic logic [4:0] fephy_dec(input logic [4:0] s);
    logic [4:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      if (ENC_TAB[i] == s) r = {1'b1, 4'(i)};
    end
    return r;
  endfunction : fephy_dec

  // Picks the best common ability; bit 3 is 100 full, bit 0 is 10 half.
  function automatic logic [2:0] fephy_res(input logic [3:0] c);
    if (c[3]) return MD_100F;
    if (c[2]) return MD_100H;
    if (c[1]) return MD_10F;
    if (c[0]) return MD_10H;
    return MD_NONE;
  endfunction : fephy_res
endpackage : fephy_pkg

// [logic/fephy_core.sv]
// Digital core of the 10/100 twisted-pair PHY with its AHB-Lite register slave.
//
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module fephy_core #(
  parameter int JAB_C = fephy_pkg::JAB_CYC,
  parameter int UNJAB_C = fephy_pkg::UNJAB_CYC,
  parameter int SQE_C = fephy_pkg::SQE_CYC,
  parameter int BIT_C = fephy_pkg::RX_BIT_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  output logic tx_take,
  output logic mlt_pos,
  output logic mlt_neg,
  output logic tp10_out,
  input wire logic rx_line,
  output logic rx_dv,
  output logic [3:0] rxd,
  output logic rx_er,
  output logic crs,
  output logic col,
  input wire logic negotiation_enable_strap,
  input wire logic [3:0] lp_ability,
  input wire logic lp_valid,
  input wire logic pd_100,
  input wire logic pd_10,
  output logic [3:0] adv_out,
  output logic link_up,
  output logic irq_n
);
  import fephy_pkg::*;

  localparam int JMAX = (JAB_C > UNJAB_C) ? JAB_C : UNJAB_C;
  localparam int JW = $clog2(JMAX + 1);
  localparam int SW = $clog2(SQE_C + 1);
  localparam int PW = $clog2(BIT_C + 1);
  localparam int PH_Q1 = BIT_C / 4;
  localparam int PH_MID = BIT_C / 2;
  localparam int PH_Q3 = 3 * BIT_C / 4;

  typedef struct packed {
    logic [4:0] sy1;
    logic [4:0] sy2;
    logic [3:0] ab1;
    logic [3:0] ab2;
    logic [1:0] stp;
    logic an_en;
    logic spd;
    logic dup;
    logic [3:0] adv;
    logic [1:0] istat;
    logic [1:0] imask;
    logic irq;
    logic link;
    logic m_spd;
    logic m_fdx;
    logic a_wr;
    logic [7:0] a_ad;
    logic [31:0] rdata;
    fephy_tx_t tst;
    logic [2:0] tb;
    logic [4:0] tsh;
    logic [10:0] tscr;
    logic nrzi;
    logic [1:0] ml;
    logic mp;
    logic mn;
    logic take;
    logic tp10;
    logic txact;
    logic jab;
    logic [JW-1:0] jc;
    logic [SW-1:0] sqe;
    logic col;
    logic rl;
    logic rs;
    logic ed;
    logic [PW-1:0] ph;
    logic [10:0] rscr;
    logic [9:0] rw;
    logic [2:0] rb;
    logic inf;
    logic [1:0] act;
    logic dv;
    logic er;
    logic crs;
    logic [3:0] rxd;
  } fephy_st_t;

  localparam fephy_st_t ST_RST = '{an_en: C_AN_RST, spd: C_SPEED_RST, dup: C_DUP_RST,
    adv: ADV_RST, tst: TX_IDLE, default: '0};

  fephy_st_t s_r;
  fephy_st_t s_nxt;
  logic smp;
  logic [9:0] w;

  //////////////////////////////////////////////////////////////////////////////
  // All state runs on hclk; line bit timing is divided from it, no other clock.
  always_comb begin
    logic acc, lvl, edg, nb, d, sc, db, tx_ok, last, m10;
    logic [4:0] dc;
    logic [2:0] md;
    {lvl, edg, nb, d, sc, db, tx_ok, last} = '0;
    dc = '0;
    md = MD_NONE;
    s_nxt = s_r;
    acc = hsel && hready && htrans[1];
    m10 = !s_r.m_spd;
    s_nxt.sy1 = {pd_10, pd_100, lp_valid, negotiation_enable_strap, rx_line};
    s_nxt.sy2 = s_r.sy1;
    s_nxt.ab1 = lp_ability;
    s_nxt.ab2 = s_r.ab1;
    s_nxt.take = 1'b0;
    s_nxt.a_wr = acc && hwrite;
    s_nxt.a_ad = haddr[7:0];
    // A write lands in its data phase; every control bit is reachable.
    if (s_r.a_wr) begin
      case (s_r.a_ad)
        A_CTRL: begin
          s_nxt.spd = hwdata[B_SPEED];
          s_nxt.an_en = hwdata[B_AN_EN];
          s_nxt.dup = hwdata[B_DUPLEX];
        end
        A_ADV: s_nxt.adv = hwdata[3:0];
        A_ISTAT: s_nxt.istat = s_r.istat & ~hwdata[1:0];
        A_IMASK: s_nxt.imask = hwdata[1:0];
        default: ;
      endcase
    end
    // The strap is taken once, two cycles after release, when its sync is valid.
    if (s_r.stp != STP_DONE) s_nxt.stp = s_r.stp + 2'h1;
    if (s_r.stp == STP_CAP) s_nxt.an_en = s_r.sy2[SY_STRAP];
    // Mode is forced, negotiated from both ability sets, or parallel detected.
    md = fephy_res(s_r.adv & s_r.ab2);
    if (!s_r.an_en) begin
      md = {1'b1, s_r.spd, s_r.dup};
    end else if (!s_r.sy2[SY_LPV]) begin
      md = s_r.sy2[SY_PD100] ? MD_100H : (s_r.sy2[SY_PD10] ? MD_10H : MD_NONE);
    end
    {s_nxt.link, s_nxt.m_spd, s_nxt.m_fdx} = md;
    if (md != {s_r.link, s_r.m_spd, s_r.m_fdx}) s_nxt.istat[IS_LINK] = 1'b1;
    // Jabber timer: one counter measures enable high, then enable low.
    if (!s_r.jab && m10) begin
      if (!tx_en) begin
        s_nxt.jc = '0;
      end else if (s_r.jc == JW'(JAB_C)) begin
        s_nxt.jab = 1'b1;
        s_nxt.jc = '0;
        s_nxt.istat[IS_JAB] = 1'b1;
      end else begin
        s_nxt.jc = s_r.jc + 1'b1;
      end
    end else if (s_r.jab) begin
      if (tx_en) begin
        s_nxt.jc = '0;
      end else if (s_r.jc == JW'(UNJAB_C)) begin
        s_nxt.jab = 1'b0;
        s_nxt.jc = '0;
      end else begin
        s_nxt.jc = s_r.jc + 1'b1;
      end
    end else begin
      s_nxt.jc = '0;
    end
    // Transmit: a symbol shifts out MSB first, one bit per cycle.
    tx_ok = tx_en && !(s_r.jab && m10);
    last = s_r.tb == (m10 ? TB_LAST10 : TB_LAST100);
    db = s_r.tsh[4];
    s_nxt.tsh = {s_r.tsh[3:0], 1'b0};
    s_nxt.tb = s_r.tb + 3'h1;
    if (s_r.sqe != '0) s_nxt.sqe = s_r.sqe - 1'b1;
    if (last) begin
      s_nxt.tb = '0;
      unique case (s_r.tst)
        TX_IDLE: begin
          if (tx_ok && m10) begin
            s_nxt.tsh = {txd, 1'b0};
            s_nxt.take = 1'b1;
            s_nxt.txact = 1'b1;
            s_nxt.tst = TX_DATA;
          end else if (tx_ok) begin
            s_nxt.tsh = SYM_J;
            s_nxt.txact = 1'b1;
            s_nxt.tst = TX_K;
          end else begin
            s_nxt.tsh = m10 ? 5'h00 : SYM_I;
            s_nxt.txact = 1'b0;
          end
        end
        TX_K: begin
          s_nxt.tsh = SYM_K;
          s_nxt.tst = TX_DATA;
        end
        TX_DATA: begin
          if (tx_ok) begin
            s_nxt.tsh = m10 ? {txd, 1'b0} : ENC_TAB[txd];
            s_nxt.take = 1'b1;
          end else if (m10) begin
            s_nxt.tsh = 5'h00;
            s_nxt.tst = TX_IDLE;
            s_nxt.txact = 1'b0;
            if (!s_nxt.jab) s_nxt.sqe = SW'(SQE_C);
          end else begin
            s_nxt.tsh = SYM_T;
            s_nxt.tst = TX_R;
          end
        end
        TX_R: begin
          s_nxt.tsh = SYM_R;
          s_nxt.tst = TX_IDLE;
        end
      endcase
    end
    // Scramble, NRZI and MLT3 only at 100; at 10 the raw bit goes out.
    sc = db ^ s_r.tscr[SCR_T1] ^ s_r.tscr[SCR_T2];
    // Bits still in the shifter when the lockout starts are dropped, not sent.
    s_nxt.tp10 = m10 && db && !s_r.jab;
    if (!m10) begin
      s_nxt.tscr = {s_r.tscr[9:0], sc};
      s_nxt.nrzi = s_r.nrzi ^ sc;
      if (s_nxt.nrzi != s_r.nrzi) s_nxt.ml = s_r.ml + 2'h1;
    end
    s_nxt.mp = !m10 && (s_nxt.ml == ML_POS);
    s_nxt.mn = !m10 && (s_nxt.ml == ML_NEG);
    // Receive bit clock: a phase counter that free-runs and locks to edges.
    lvl = s_r.sy2[SY_LINE];
    edg = lvl ^ s_r.rl;
    s_nxt.rl = lvl;
    s_nxt.ph = (s_r.ph == PW'(BIT_C - 1)) ? '0 : s_r.ph + 1'b1;
    if (edg && !m10) begin
      s_nxt.ph = '0;
    end else if (edg && s_r.ph >= PW'(PH_Q1) && s_r.ph < PW'(PH_Q3)) begin
      s_nxt.ph = PW'(PH_MID);
    end
    smp = s_r.ph == PW'(m10 ? PH_Q3 : PH_MID);
    s_nxt.ed = smp ? 1'b0 : (s_r.ed || edg);
    w = {s_r.rw[8:0], 1'b0};
    if (smp) begin
      nb = m10 ? lvl : (lvl ^ s_r.rs);
      s_nxt.rs = lvl;
      d = m10 ? nb : (nb ^ s_r.rscr[SCR_T1] ^ s_r.rscr[SCR_T2]);
      if (!m10) s_nxt.rscr = {s_r.rscr[9:0], nb};
      s_nxt.er = 1'b0;
      if (m10) begin
        s_nxt.act = (s_r.ed || edg) ? ACT_HOLD : ((s_r.act != '0) ? s_r.act - 2'h1 : '0);
        s_nxt.crs = s_nxt.act != '0;
        s_nxt.dv = s_nxt.crs;
        s_nxt.inf = 1'b0;
        s_nxt.rw = {6'h00, d, s_r.rw[3:1]};
        s_nxt.rb = (s_r.rb == TB_LAST10) ? 3'h0 : s_r.rb + 3'h1;
        if (s_r.rb == TB_LAST10) s_nxt.rxd = s_nxt.rw[3:0];
      end else begin
        w = {s_r.rw[8:0], d};
        s_nxt.rw = w;
        s_nxt.rb = (s_r.rb == TB_LAST100) ? 3'h0 : s_r.rb + 3'h1;
        dc = fephy_dec(w[4:0]);
        if (!s_r.inf) begin
          if (w == {SYM_J, SYM_K}) begin
            s_nxt.inf = 1'b1;
            s_nxt.rb = 3'h0;
            s_nxt.crs = 1'b1;
            s_nxt.dv = 1'b1;
            s_nxt.rxd = NIB_PRE;
          end
        end else if (s_r.rb == TB_LAST100) begin
          if (w[4:0] == SYM_T || w[4:0] == SYM_I) begin
            s_nxt.inf = 1'b0;
            s_nxt.crs = 1'b0;
            s_nxt.dv = 1'b0;
          end else if (dc[4]) begin
            s_nxt.rxd = dc[3:0];
          end else begin
            s_nxt.er = 1'b1;
          end
        end
      end
    end
    // Collision: lockout, SQE pulse, or both directions busy in half duplex.
    s_nxt.col = (s_nxt.jab && m10) || (s_nxt.sqe != '0) ||
      (!s_r.m_fdx && s_nxt.txact && s_nxt.crs);
    s_nxt.irq = |(s_nxt.istat & s_nxt.imask);
    // Read data is captured in the address phase, after any write lands.
    s_nxt.rdata = '0;
    if (acc && !hwrite) begin
      case (haddr[7:0])
        A_CTRL: begin
          s_nxt.rdata[B_SPEED] = s_nxt.spd;
          s_nxt.rdata[B_AN_EN] = s_nxt.an_en;
          s_nxt.rdata[B_DUPLEX] = s_nxt.dup;
        end
        A_STAT: begin
          s_nxt.rdata[ST_LINK] = s_nxt.link;
          s_nxt.rdata[ST_SPD] = s_nxt.m_spd;
          s_nxt.rdata[ST_FDX] = s_nxt.m_fdx;
          s_nxt.rdata[ST_JAB] = s_nxt.jab;
          s_nxt.rdata[ST_AN] = s_nxt.an_en;
        end
        A_ADV: s_nxt.rdata[3:0] = s_nxt.adv;
        A_ISTAT: s_nxt.rdata[1:0] = s_nxt.istat;
        A_IMASK: s_nxt.rdata[1:0] = s_nxt.imask;
        default: ;
      endcase
    end
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= ST_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs come from the state register, except the nibble take, which comes from s_nxt, and the tied-off ready and response.
  assign hrdata = s_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign tx_take = s_nxt.take && ce;
  assign mlt_pos = s_r.mp;
  assign mlt_neg = s_r.mn;
  assign tp10_out = s_r.tp10;
  assign rx_dv = s_r.dv;
  assign rxd = s_r.rxd;
  assign rx_er = s_r.er;
  assign crs = s_r.crs;
  assign col = s_r.col;
  assign adv_out = s_r.adv;
  assign link_up = s_r.link;
  assign irq_n = !s_r.irq;

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the core's own behaviour.
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn || !ce);

  chk_jab_entry: assert property (!s_r.jab && !s_r.m_spd && tx_en &&
    s_r.jc == JW'(JAB_C) |=> s_r.jab && s_r.col) else $error("jabber lock missed");
  chk_jab_quiet: assert property (s_r.jab && !s_r.m_spd |-> !tx_take ##1 !s_r.tp10)
    else $error("transmit during lockout");
  chk_jab_restart: assert property (!s_r.jab && !s_r.m_spd && !tx_en |=> s_r.jc == '0)
    else $error("jabber count kept");
  chk_jab_release: assert property (s_r.jab && !tx_en && s_r.jc == JW'(UNJAB_C)
    |=> !s_r.jab) else $error("lockout not released");
  chk_sqe_pulse: assert property ($fell(s_r.txact) && !s_r.m_spd && !s_r.jab
    |-> s_r.col [*2]) else $error("no collision test pulse");
  chk_forced_mode: assert property (!s_r.an_en ##1 !s_r.an_en |->
    s_r.m_spd == $past(s_r.spd) && s_r.m_fdx == $past(s_r.dup)) else $error("forced mode");
  chk_an_best: assert property (s_r.an_en && s_r.sy2[SY_LPV] && s_r.adv[3] && s_r.ab2[3]
    |=> s_r.m_spd && s_r.m_fdx) else $error("priority wrong");
  chk_strap_copy: assert property (s_r.stp == STP_CAP |=>
    s_r.an_en == $past(s_r.sy2[SY_STRAP])) else $error("strap not copied");
  chk_scr_bypass: assert property (!s_r.m_spd |=> $stable(s_r.tscr))
    else $error("scrambler ran at 10");
  chk_rx_clock: assert property (s_r.ph == PW'(BIT_C - 1) |=> s_r.ph == '0)
    else $error("receive clock stalled");
  cov_jabber: cover property (s_r.jab && !s_r.m_spd);
  cov_sqe: cover property ($fell(s_r.txact) && !s_r.m_spd);
  cov_rx_frame: cover property ($rose(s_r.dv) && s_r.m_spd);
endmodule : fephy_core

// [dv/fephy_mac_model.sv]
// Behavioural MAC that feeds nibbles to the transmit side of the PHY core.
`timescale 1ns/1ps
module fephy_mac_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic [7:0] n_nib,
  input wire logic hold,
  input wire logic tx_take,
  output logic tx_en,
  output logic [3:0] txd
);
  logic [7:0] left;
  logic last;

  // The frame ends after the last take unless hold keeps enable up on purpose.
  assign last = (left <= 8'h1) && !hold;

  // Each nibble stays put until the PHY takes it; idle data is zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_en <= 1'b0;
      txd <= 4'h0;
      left <= 8'h0;
    end else if (go && !tx_en) begin
      tx_en <= 1'b1;
      txd <= 4'h9;
      left <= n_nib;
    end else if (tx_en && tx_take) begin
      left <= (left == 8'h0) ? 8'h0 : left - 8'h1;
      txd <= last ? 4'h0 : txd + 4'h3;
      tx_en <= !last;
    end else if (tx_en && !hold && left == 8'h0) begin
      tx_en <= 1'b0;
      txd <= 4'h0;
    end
  end
endmodule : fephy_mac_model

// [dv/fephy_core_tb_top.sv]
// Self-checking testbench of the PHY core: registers, negotiation, jabber and coding paths.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module fephy_core_tb_top;
  import fephy_pkg::*;
  localparam int JC = 40;
  localparam int UC = 60;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic strap = 1'b1;
  logic lp_valid = 1'b0;
  logic pd_100 = 1'b0;
  logic pd_10 = 1'b0;
  logic [3:0] lp_ability = 4'h0;
  logic rx_line = 1'b0;
  logic go = 1'b0;
  logic hold = 1'b0;
  logic [7:0] n_nib = 8'h0;
  logic hreadyout, hresp, tx_en, tx_take, mlt_pos, mlt_neg, tp10_out;
  logic rx_dv, rx_er, crs, col, link_up, irq_n;
  logic [3:0] txd, rxd, adv_out;
  logic dv_d = 1'b0;
  logic [3:0] rxd_d = 4'h0;
  logic [3:0] rxq[$];
  int fail_count = 0;
  int check_count = 0;
  int takes = 0;
  int mlt_bad = 0;
  int mlt_act = 0;
  int er_seen = 0;

  //////////////////////////////////////////////////////////////////////////////////////////
  // The clock runs at 20 MHz.
  always #25 hclk = ~hclk;

  fephy_core #(.JAB_C(JC), .UNJAB_C(UC)) DUT (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_en(tx_en), .txd(txd),
    .tx_take(tx_take), .mlt_pos(mlt_pos), .mlt_neg(mlt_neg), .tp10_out(tp10_out),
    .rx_line(rx_line), .rx_dv(rx_dv), .rxd(rxd), .rx_er(rx_er), .crs(crs), .col(col),
    .negotiation_enable_strap(strap), .lp_ability(lp_ability), .lp_valid(lp_valid),
    .pd_100(pd_100), .pd_10(pd_10), .adv_out(adv_out), .link_up(link_up), .irq_n(irq_n)
  );

  fephy_mac_model mac (
    .hclk(hclk), .hresetn(hresetn), .go(go), .n_nib(n_nib), .hold(hold),
    .tx_take(tx_take), .tx_en(tx_en), .txd(txd)
  );

  // Tallies takes, line activity and received nibbles as the core presents them.
  always @(posedge hclk) begin
    if (tx_take === 1'b1) takes++;
    if (mlt_pos === 1'b1 && mlt_neg === 1'b1) mlt_bad++;
    if (mlt_pos === 1'b1 || mlt_neg === 1'b1) mlt_act++;
    if (rx_dv === 1'b1 && rx_er === 1'b1) er_seen++;
    if (rx_dv === 1'b1 && (dv_d !== 1'b1 || rxd !== rxd_d)) rxq.push_back(rxd);
    dv_d = rx_dv;
    rxd_d = rxd;
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  task test_done;
    if (fail_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // Waits a bounded number of edges for col or tx_en to reach a level.
  task wait_for(input bit on_col, input logic v, input int lim);
    int k;
    k = 0;
    while ((on_col ? col : tx_en) !== v && k < lim) begin
      @(posedge hclk);
      k++;
    end
    if (k >= lim) begin
      fail_count++;
      test_done();
    end
  endtask : wait_for

  task wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (k >= 20) begin
      fail_count++;
      test_done();
    end
  endtask : wait_rdy

  // One single-word transfer; read data lands in rd.
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task do_reset(input logic s);
    hresetn <= 1'b0;
    strap <= s;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask : do_reset

  task pulse_go(input logic [7:0] n, input logic h);
    n_nib <= n;
    hold <= h;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    @(posedge hclk);
  endtask : pulse_go

  function automatic logic [2:0] best(input logic [3:0] c);
    best = c[3] ? 3'h7 : c[2] ? 3'h3 : c[1] ? 3'h5 : c[0] ? 3'h1 : 3'h0;
  endfunction : best

  //////////////////////////////////////////////////////////////////////////////////////////
  task t_reset(input logic s);
    do_reset(s);
    bus(A_CTRL, 1'b0, 32'h0);
    `CHK(rd, {18'h0, 1'b1, s, 3'h0, 1'b1, 8'h0})
    bus(A_STAT, 1'b0, 32'h0);
    `CHK(rd[4], s)
    bus(A_ADV, 1'b0, 32'h0);
    `CHK(rd, 32'hf)
    bus(8'h14, 1'b0, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(adv_out, 4'hf)
  endtask : t_reset

  task t_an;
    lp_valid <= 1'b1;
    for (int c = 0; c < 16; c++) begin
      lp_ability <= 4'(c);
      repeat (6) @(posedge hclk);
      bus(A_STAT, 1'b0, 32'h0);
      `CHK(rd[2:0], best(4'(c)))
    end
    bus(A_ADV, 1'b1, 32'h3);
    repeat (6) @(posedge hclk);
    bus(A_STAT, 1'b0, 32'h0);
    `CHK(rd[2:0], 3'h5)
    `CHK(adv_out, 4'h3)
    `CHK(link_up, 1'b1)
    bus(A_ADV, 1'b1, 32'hf);
  endtask : t_an

  task t_pd;
    lp_valid <= 1'b0;
    pd_100 <= 1'b1;
    repeat (6) @(posedge hclk);
    bus(A_STAT, 1'b0, 32'h0);
    `CHK(rd[2:0], 3'h3)
    pd_100 <= 1'b0;
    pd_10 <= 1'b1;
    repeat (6) @(posedge hclk);
    bus(A_STAT, 1'b0, 32'h0);
    `CHK(rd[2:0], 3'h1)
  endtask : t_pd

  task t_forced;
    bus(A_IMASK, 1'b1, 32'h1);
    bus(A_ISTAT, 1'b1, 32'h3);
    for (int s = 3; s >= 0; s--) begin
      bus(A_CTRL, 1'b1, {18'h0, s[1], 4'h0, s[0], 8'h0});
      repeat (4) @(posedge hclk);
      bus(A_STAT, 1'b0, 32'h0);
      `CHK(rd[4:0], {2'h0, s[0], s[1], 1'b1})
    end
    `CHK(irq_n, 1'b0)
    bus(A_ISTAT, 1'b1, 32'h1);
    repeat (2) @(posedge hclk);
    `CHK(irq_n, 1'b1)
  endtask : t_forced

  task t_sqe;
    int hi;
    hi = 0;
    takes = 0;
    mlt_act = 0;
    pulse_go(8'd4, 1'b0);
    wait_for(1'b0, 1'b0, 100);
    repeat (60) begin
      @(posedge hclk);
      if (col === 1'b1) hi++;
    end
    `CHK(takes, 4)
    `CHK(hi inside {[1:40]}, 1'b1)
    `CHK(mlt_act, 0)
  endtask : t_sqe

  task t_jab;
    pulse_go(8'd0, 1'b1);
    repeat (30) @(posedge hclk);
    `CHK(col, 1'b0)
    hold <= 1'b0;
    repeat (45) @(posedge hclk);
    pulse_go(8'd0, 1'b1);
    repeat (30) @(posedge hclk);
    `CHK(col, 1'b0)
    wait_for(1'b1, 1'b1, 20);
    bus(A_STAT, 1'b0, 32'h0);
    `CHK(rd[3], 1'b1)
    takes = 0;
    repeat (30) @(posedge hclk);
    `CHK(takes, 0)
    `CHK(tp10_out, 1'b0)
    hold <= 1'b0;
    repeat (UC - 10) @(posedge hclk);
    `CHK(col, 1'b1)
    wait_for(1'b1, 1'b0, 30);
  endtask : t_jab

  task t_tx100;
    bus(A_CTRL, 1'b1, 32'h2100);
    repeat (4) @(posedge hclk);
    takes = 0;
    mlt_bad = 0;
    mlt_act = 0;
    pulse_go(8'd8, 1'b0);
    wait_for(1'b0, 1'b0, 300);
    repeat (20) @(posedge hclk);
    `CHK(takes, 8)
    `CHK(mlt_bad, 0)
    `CHK(mlt_act > 0, 1'b1)
  endtask : t_tx100

  // Sends a scrambled NRZI frame at the 400 ns link bit time, eight clocks a bit.
  task t_rx100;
    logic [4:0] sy[$];
    logic [3:0] ex[$];
    logic [10:0] sr;
    logic s;
    logic lvl;
    sy = '{SYM_I, SYM_I, SYM_I, SYM_I, SYM_J, SYM_K, ENC_TAB[4'ha], ENC_TAB[4'h3],
      ENC_TAB[4'hc], ENC_TAB[4'h6], SYM_T, SYM_R, SYM_I, SYM_I, SYM_I, SYM_I};
    ex = '{4'h5, 4'ha, 4'h3, 4'hc, 4'h6};
    sr = 11'h5a5;
    lvl = rx_line;
    rxq.delete();
    er_seen = 0;
    @(posedge hclk);
    foreach (sy[i]) begin
      for (int b = 4; b >= 0; b--) begin
        s = sy[i][b] ^ sr[SCR_T1] ^ sr[SCR_T2];
        sr = {sr[9:0], s};
        lvl = lvl ^ s;
        rx_line <= lvl;
        repeat (8) @(posedge hclk);
      end
    end
    repeat (20) @(posedge hclk);
    `CHK(rxq.size(), 5)
    foreach (ex[i]) `CHK(rxq[i], ex[i])
    `CHK(er_seen, 0)
    `CHK(crs, 1'b0)
  endtask : t_rx100

  //////////////////////////////////////////////////////////////////////////////////////////
  // Main sequence; the second reset runs with the strap low.
  initial begin
    t_reset(1'b1);
    t_reset(1'b0);
    t_reset(1'b1);
    t_an();
    t_pd();
    t_forced();
    t_sqe();
    t_jab();
    t_tx100();
    t_rx100();
    test_done();
  end
endmodule : fephy_core_tb_top
